// File: sim/hboa_arbiter_bench.sv
`timescale 1ns/1ps
`define CHK(n, e, a) begin num_checks++; if ((a) !== (e)) begin bad_count++; \
  $display("mismatch %s expected %h seen %h", n, e, a); end end
`define UNTIL(c) for (int w = 0; w < 80 && !(c); w++) @(negedge ref_clk)
// ****
// Bench
// ****
module hboa_arbiter_bench;
  logic ref_clk = 1'h0;
  logic rst = 1'h1;
  logic dma_need = 1'h0;
  logic slave_need = 1'h0;
  logic cycle_done = 1'h0;
  logic rel_req = 1'h0;
  logic chain_want = 1'h0;
  logic req_n, grant_n, rel_n, chreq_n, chgnt_n, internal_grant, chain_owns, release_pending;
  int bad_count = 0;
  int num_checks = 0;
  int cycles = 0;
  always #2.5 ref_clk = ~ref_clk;
  hboa_host_model host (.ref_clk(ref_clk), .bus_request_out_n(req_n), .chain_grant_out_n(chgnt_n),
    .rel_req(rel_req), .chain_want(chain_want), .bus_grant_in_n(grant_n),
    .release_request_in_n(rel_n), .chain_request_in_n(chreq_n));
  hboa_arbiter #(.LINE_BEATS(4)) dut (.ref_clk(ref_clk), .rst(rst), .bus_request_out_n(req_n),
    .bus_grant_in_n(grant_n), .release_request_in_n(rel_n), .chain_request_in_n(chreq_n),
    .chain_grant_out_n(chgnt_n), .dma_need(dma_need), .slave_need(slave_need),
    .cycle_done(cycle_done), .internal_grant(internal_grant), .chain_owns(chain_owns),
    .release_pending(release_pending));
  task summarize;
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : summarize
  // Tests need under two hundred cycles
  always @(posedge ref_clk)
  begin
    cycles++;
    if (cycles == 6000)
    begin
      bad_count++;
      summarize();
    end
  end
  task pulse_done;
    cycle_done = 1'h1;
    @(negedge ref_clk);
    cycle_done = 1'h0;
    @(negedge ref_clk);
  endtask : pulse_done
  // Grant pin idle, then the synchroniser latency
  task wait_idle;
    `UNTIL(grant_n === 1'h1 && req_n === 1'h1);
    repeat (6) @(negedge ref_clk);
  endtask : wait_idle
  task t_dma;
    dma_need = 1'h1;
    `UNTIL(internal_grant === 1'h1);
    `CHK("internal", 1'h1, internal_grant)
    `CHK("request", 1'h0, req_n)
    `CHK("chain grant", 1'h1, chgnt_n)
    dma_need = 1'h0;
    pulse_done();
    `CHK("request", 1'h1, req_n)
    wait_idle();
    $display("test dma done");
  endtask : t_dma
  task t_chain;
    chain_want = 1'h1;
    `UNTIL(chain_owns === 1'h1);
    `CHK("chain grant", 1'h0, chgnt_n)
    `CHK("internal", 1'h0, internal_grant)
    chain_want = 1'h0;
    `UNTIL(req_n === 1'h1);
    `CHK("request", 1'h1, req_n)
    wait_idle();
    $display("test chain done");
  endtask : t_chain
  task t_rr;
    slave_need = 1'h1;
    chain_want = 1'h1;
    `UNTIL(internal_grant === 1'h1 || chain_owns === 1'h1);
    `CHK("internal first", 1'h1, internal_grant)
    pulse_done();
    `UNTIL(chain_owns === 1'h1);
    `CHK("chain second", 1'h1, chain_owns)
    chain_want = 1'h0;
    `UNTIL(internal_grant === 1'h1);
    `CHK("internal third", 1'h1, internal_grant)
    slave_need = 1'h0;
    pulse_done();
    `CHK("request", 1'h1, req_n)
    wait_idle();
    $display("test round robin done");
  endtask : t_rr
  task t_release;
    dma_need = 1'h1;
    `UNTIL(internal_grant === 1'h1);
    rel_req = 1'h1;
    repeat (6) @(negedge ref_clk);
    repeat (3) pulse_done();
    `CHK("pending", 1'h1, release_pending)
    `CHK("mid line", 1'h1, internal_grant)
    pulse_done();
    `CHK("line end", 1'h0, internal_grant)
    dma_need = 1'h0;
    rel_req = 1'h0;
    wait_idle();
    $display("test release done");
  endtask : t_release
  // New need right after a release: no request while the host still grants
  task t_refuse;
    dma_need = 1'h1;
    `UNTIL(internal_grant === 1'h1);
    dma_need = 1'h0;
    pulse_done();
    dma_need = 1'h1;
    `CHK("refused", 1'h1, req_n)
    repeat (2) @(negedge ref_clk);
    `CHK("still refused", 1'h1, req_n)
    `UNTIL(internal_grant === 1'h1);
    `CHK("internal again", 1'h1, internal_grant)
    dma_need = 1'h0;
    pulse_done();
    `CHK("request", 1'h1, req_n)
    wait_idle();
    $display("test refuse done");
  endtask : t_refuse
  initial
  begin
    repeat (8) @(negedge ref_clk);
    rst = 1'h0;
    @(negedge ref_clk);
    `CHK("request", 1'h1, req_n)
    `CHK("chain grant", 1'h1, chgnt_n)
    t_dma();
    t_chain();
    t_rr();
    t_release();
    t_refuse();
    summarize();
  end
endmodule : hboa_arbiter_bench
bind hboa_arbiter hboa_arbiter_chk #(.LINE_BEATS(LINE_BEATS)) u_chk (.ref_clk(ref_clk), .rst(rst),
  .bus_request_out_n(bus_request_out_n), .bus_grant_in_n(bus_grant_in_n),
  .release_request_in_n(release_request_in_n), .chain_request_in_n(chain_request_in_n),
  .chain_grant_out_n(chain_grant_out_n), .dma_need(dma_need), .slave_need(slave_need),
  .cycle_done(cycle_done), .internal_grant(internal_grant), .chain_owns(chain_owns),
  .release_pending(release_pending));

// File: sim/hboa_arbiter_chk.sv
`timescale 1ns/1ps
// ****
// Ownership checks
// ****
module hboa_arbiter_chk #(
  parameter int LINE_BEATS = 4
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // Pins
  input wire logic bus_request_out_n,
  input wire logic bus_grant_in_n,
  input wire logic release_request_in_n,
  input wire logic chain_request_in_n,
  input wire logic chain_grant_out_n,
  // Engines
  input wire logic dma_need,
  input wire logic slave_need,
  input wire logic cycle_done,
  input wire logic internal_grant,
  input wire logic chain_owns,
  input wire logic release_pending
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  wire need = dma_need | slave_need;
  // Owned cycles within the current line, counted while internal engines own the bus
  int done_cnt;
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      done_cnt <= 0;
    else if (!internal_grant)
      done_cnt <= 0;
    else if (cycle_done)
      done_cnt <= (done_cnt == LINE_BEATS - 1) ? 0 : done_cnt + 1;
  end
  // Chain pin quiet long enough to pass the synchroniser
  sequence s_quiet_chain; chain_request_in_n [*4]; endsequence
  sequence s_last_done; internal_grant && cycle_done && !need; endsequence
  AST_NEED_REQ: assert property ((need && bus_grant_in_n) [*6] |-> ##[0:8] !bus_request_out_n)
    else $error("no bus request for internal need");
  AST_START_IDLE: assert property ($fell(bus_request_out_n) |->
    $past(bus_grant_in_n, 5) && $past(bus_grant_in_n, 6))
    else $error("bus request started under grant");
  AST_OWN_REQ: assert property (internal_grant || chain_owns |-> !bus_request_out_n)
    else $error("owner without bus request");
  AST_CHAIN_ASK: assert property ((!chain_request_in_n && bus_grant_in_n) [*6] |->
    ##[0:8] !bus_request_out_n)
    else $error("no bus request for chained device");
  AST_CHAIN_WIN: assert property (!chain_grant_out_n |-> chain_owns && !internal_grant)
    else $error("chain grant while chain does not own");
  AST_CHAIN_HOLD: assert property (!chain_grant_out_n && !chain_request_in_n
    |=> !chain_grant_out_n)
    else $error("chain grant dropped under request");
  AST_LAST_DONE: assert property (s_quiet_chain ##0 s_last_done |=> bus_request_out_n)
    else $error("bus request kept with no requester");
  AST_REL_LATCH: assert property ((internal_grant && !release_request_in_n) [*6]
    |-> release_pending)
    else $error("release request not latched");
  AST_REL_DONE: assert property ((release_pending and s_last_done) |=> !internal_grant)
    else $error("bus kept after release");
  AST_REL_LINE: assert property (internal_grant && release_pending && cycle_done
    && done_cnt == LINE_BEATS - 1 |=> !internal_grant)
    else $error("bus kept past line end under release");
endmodule : hboa_arbiter_chk

// File: sim/hboa_host_model.sv
`timescale 1ns/1ps
// ****
// Host processor and chained device
// ****
module hboa_host_model #(
  parameter int GRANT_DELAY = 2,
  parameter int CHAIN_HOLD = 4
) (
  // Clock
  input wire logic ref_clk,
  // From the block
  input wire logic bus_request_out_n,
  input wire logic chain_grant_out_n,
  // Bench controls
  input wire logic rel_req,
  input wire logic chain_want,
  // To the block, active low
  output logic bus_grant_in_n = 1'h1,
  output logic release_request_in_n,
  output logic chain_request_in_n = 1'h1
);
  int wait_cnt = 0;
  int hold_cnt = 0;
  assign release_request_in_n = !rel_req;
  always @(posedge ref_clk)
  begin
    // Grant is kept until the request is withdrawn
    if (bus_request_out_n)
      {bus_grant_in_n, wait_cnt} <= {1'h1, 32'h0};
    else if (wait_cnt == GRANT_DELAY)
      bus_grant_in_n <= 1'h0;
    else
      wait_cnt <= wait_cnt + 1;
    // Ask only while the chain grant is idle, let go after a few owned cycles
    if (chain_request_in_n)
      chain_request_in_n <= !(chain_want && chain_grant_out_n);
    else if (hold_cnt == CHAIN_HOLD)
      {chain_request_in_n, hold_cnt} <= {1'h1, 32'h0};
    else if (!chain_grant_out_n)
      hold_cnt <= hold_cnt + 1;
  end
endmodule : hboa_host_model

// File: verilog/hboa_arbiter.sv
`timescale 1ns/1ps

// Notes on behaviour
// - Request the bus when DMA, direct-slave or the chained device needs it.
// - Start asserting the bus request only while grant is inactive.
// - On grant, run our own transaction or pass grant to chained device.
// - Release request low while owning: give up at line end, or at a cycle end with no further internal need.
// - Chained request low makes us request the bus on its behalf.
// - Round-robin between internal and chained; chain grant only when chained wins.
module hboa_arbiter #(
  parameter int LINE_BEATS = hboa_pkg::LINE_BEATS
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // Local-bus ownership pins, active low
  output logic bus_request_out_n,
  input wire logic bus_grant_in_n,
  input wire logic release_request_in_n,
  input wire logic chain_request_in_n,
  output logic chain_grant_out_n,
  // Internal engines (same clock, active high)
  input wire logic dma_need,
  input wire logic slave_need,
  input wire logic cycle_done,
  output logic internal_grant,
  output logic chain_owns,
  output logic release_pending
);

  // ****************************************************************
  // Pin synchronisation
  // ****************************************************************
  hboa_pkg::hboa_pins_type pins_raw;
  hboa_pkg::hboa_pins_type pins;

  assign pins_raw = '{bus_grant_in_n, release_request_in_n, chain_request_in_n};

  hboa_sync #(
    .WIDTH(3),
    .IDLE(3'h7)
  ) u_sync (
    .ref_clk(ref_clk),
    .rst(rst),
    .din(pins_raw),
    .dout(pins)
  );

  // ****************************************************************
  // Decode
  // ****************************************************************
  wire granted = (pins.bus_grant_in_n == hboa_pkg::PIN_ACTIVE);
  wire chain_req = (pins.chain_request_in_n == hboa_pkg::PIN_ACTIVE);
  wire release_req = (pins.release_request_in_n == hboa_pkg::PIN_ACTIVE);
  wire internal_req = dma_need | slave_need;
  wire any_req = internal_req | chain_req;

  // Last winner steers who goes first when both want the bus
  logic last_winner;
  wire pick_chain = chain_req & (~internal_req | (last_winner == hboa_pkg::WIN_INTERNAL));

  localparam int BW = $clog2(LINE_BEATS + 1);
  logic [BW-1:0] beats;
  logic release_seen;
  wire line_end = cycle_done & (beats == BW'(LINE_BEATS - 1));

  hboa_pkg::hboa_state_type state;
  hboa_pkg::hboa_state_type next_state;
  logic next_last_winner;

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb
  begin
    next_state = state;
    next_last_winner = last_winner;
    unique case (state)
      hboa_pkg::ST_IDLE:
      begin
        // Only start a request while grant is idle, so a stale grant is not taken
        if (any_req && !granted)
        begin
          next_state = hboa_pkg::ST_REQUEST;
        end
      end
      hboa_pkg::ST_REQUEST:
      begin
        if (!any_req)
        begin
          next_state = hboa_pkg::ST_RELEASE;
        end
        else if (granted)
        begin
          if (pick_chain)
          begin
            next_state = hboa_pkg::ST_OWN_CHAIN;
            next_last_winner = hboa_pkg::WIN_CHAIN;
          end
          else
          begin
            next_state = hboa_pkg::ST_OWN_INTERNAL;
            next_last_winner = hboa_pkg::WIN_INTERNAL;
          end
        end
      end
      hboa_pkg::ST_OWN_INTERNAL:
      begin
        // Hand over only at a cycle boundary or line boundary
        if (release_seen && (line_end || (cycle_done && !internal_req)))
        begin
          next_state = hboa_pkg::ST_RELEASE;
        end
        else if (cycle_done && (!internal_req || chain_req))
        begin
          if (chain_req)
          begin
            next_state = hboa_pkg::ST_OWN_CHAIN;
            next_last_winner = hboa_pkg::WIN_CHAIN;
          end
          else
          begin
            next_state = hboa_pkg::ST_RELEASE;
          end
        end
      end
      hboa_pkg::ST_OWN_CHAIN:
      begin
        // Chain grant is held until the chained device lets go
        if (!chain_req)
        begin
          if (internal_req && !release_seen)
          begin
            next_state = hboa_pkg::ST_OWN_INTERNAL;
            next_last_winner = hboa_pkg::WIN_INTERNAL;
          end
          else
          begin
            next_state = hboa_pkg::ST_RELEASE;
          end
        end
      end
      hboa_pkg::ST_RELEASE:
      begin
        // Wait for the host to drop grant before any new request
        if (!granted)
        begin
          next_state = hboa_pkg::ST_IDLE;
        end
      end
    endcase
  end

  // ****************************************************************
  // State, winner, beat count, release latch
  // ****************************************************************
  wire owning = (state == hboa_pkg::ST_OWN_INTERNAL);
  wire leaving = (next_state == hboa_pkg::ST_RELEASE) || (next_state == hboa_pkg::ST_IDLE);

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      state <= hboa_pkg::ST_IDLE;
      last_winner <= hboa_pkg::WIN_INTERNAL;
    end
    else
    begin
      state <= next_state;
      last_winner <= next_last_winner;
    end
  end

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      beats <= '0;
    end
    else if (!owning || line_end)
    begin
      beats <= '0;
    end
    else if (cycle_done)
    begin
      beats <= beats + BW'(1);
    end
  end

  // Release request is latched; a new low level wins over the clear on exit
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      release_seen <= 1'b0;
    end
    else if (release_req && state != hboa_pkg::ST_IDLE)
    begin
      release_seen <= 1'b1;
    end
    else if (leaving)
    begin
      release_seen <= 1'b0;
    end
  end

  // ****************************************************************
  // Pin outputs, registered
  // ****************************************************************
  wire next_req_active = (next_state == hboa_pkg::ST_REQUEST)
                      || (next_state == hboa_pkg::ST_OWN_INTERNAL)
                      || (next_state == hboa_pkg::ST_OWN_CHAIN);

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      bus_request_out_n <= hboa_pkg::PIN_IDLE;
      chain_grant_out_n <= hboa_pkg::PIN_IDLE;
    end
    else
    begin
      bus_request_out_n <= next_req_active ? hboa_pkg::PIN_ACTIVE : hboa_pkg::PIN_IDLE;
      chain_grant_out_n <= (next_state == hboa_pkg::ST_OWN_CHAIN)
                           ? hboa_pkg::PIN_ACTIVE : hboa_pkg::PIN_IDLE;
    end
  end

  assign internal_grant = owning;
  assign chain_owns = (state == hboa_pkg::ST_OWN_CHAIN);
  assign release_pending = release_seen;

endmodule : hboa_arbiter

// File: verilog/hboa_pkg.sv
package hboa_pkg;

  // ****************************************************************
  // Ownership pin levels (all active low)
  // ****************************************************************
  localparam logic PIN_ACTIVE = 1'h0;
  localparam logic PIN_IDLE = 1'h1;

  // ****************************************************************
  // Round-robin winners
  // ****************************************************************
  localparam logic WIN_INTERNAL = 1'h0;
  localparam logic WIN_CHAIN = 1'h1;

  // Default number of owned cycles that make one cache-line transfer
  localparam int LINE_BEATS = 4;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_REQUEST,
    ST_OWN_INTERNAL,
    ST_OWN_CHAIN,
    ST_RELEASE
  } hboa_state_type;

  // Raw active-low pins from the far side, as one bundle
  typedef struct packed {
    logic bus_grant_in_n;
    logic release_request_in_n;
    logic chain_request_in_n;
  } hboa_pins_type;

endpackage : hboa_pkg

// File: verilog/hboa_sync.sv
`timescale 1ns/1ps

// ****************************************************************
// Three-stage synchroniser; a change counts once stages two and three agree
// ****************************************************************
module hboa_sync #(
  parameter int WIDTH = 3,
  parameter logic [WIDTH-1:0] IDLE = '1
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // Data
  input wire logic [WIDTH-1:0] din,
  output logic [WIDTH-1:0] dout
);

  logic [WIDTH-1:0] stage1;
  logic [WIDTH-1:0] stage2;
  logic [WIDTH-1:0] stage3;
  logic [WIDTH-1:0] next_dout;

  // Hold the last agreed level while the two late stages still differ
  genvar i;
  generate
    for (i = 0; i < WIDTH; i++)
    begin : g_bit
      assign next_dout[i] = (stage2[i] == stage3[i]) ? stage3[i] : dout[i];
    end
  endgenerate

  // Reset to the idle pin levels so that no false edge follows reset
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      stage1 <= IDLE;
      stage2 <= IDLE;
      stage3 <= IDLE;
      dout <= IDLE;
    end
    else
    begin
      stage1 <= din;
      stage2 <= stage1;
      stage3 <= stage2;
      dout <= next_dout;
    end
  end

endmodule : hboa_sync
